// >>> inc/timebase_map.vh
`ifndef TIMEBASE_MAP_VH
`define TIMEBASE_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_STATUS        12'h000
`define OFS_IRQ_ENABLE        12'h004
`define OFS_TIMER_MODE_SELECT 12'h008
`define OFS_IRQ_CLEAR         12'h00C
`define OFS_TIMER_COUNT       12'h010
`define OFS_WATCH_CLEAR       12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_TIMER_OVERFLOW    2
`define BIT_TIMEBASE_SELECT   3
`define BIT_WATCH_CLEAR_CMD   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TIMER_MODE_SELECT 4'h0
`define RST_IRQ_ENABLE        4'h0
`define RST_IRQ_STATUS        4'h0
`define RST_TIMER_COUNT       8'h00

// ----------------------------------------------------------------
// Counter widths and taps
// ----------------------------------------------------------------
`define SYS_DIV_WIDTH         11
`define WATCH_DIV_WIDTH       5
`define CRYSTAL_DIV_WIDTH     3
`define TIMER_ALL_ONES        8'hFF
`define TAP_SYS_2048          10
`define TAP_SYS_1024          9
`define TAP_SYS_512           8
`define TAP_SYS_128           6
`define TAP_SYS_32            4
`define TAP_SYS_8             2
`define TAP_SYS_4             1
`define TAP_SYS_2             0
`define TAP_WATCH_32          4
`define TAP_WATCH_16          3
`define TAP_WATCH_8           2
`define TAP_WATCH_2           0
`define TAP_CRYSTAL_HALF      1
`define TAP_CRYSTAL_EIGHTH    2

`endif

// >>> src/prescale_counter.v
// Binary up-counter with hold, synchronous clear and carry taps
module prescale_counter #(
	parameter WIDTH = 11
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rstn,
	// Control
	input  wire             clear,
	input  wire             inc,
	// State and taps
	output reg  [WIDTH-1:0] count,
	output wire [WIDTH-1:0] carry
);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Clear wins over increment
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			count <= {WIDTH{1'b0}};
		else if (clear)
			count <= {WIDTH{1'b0}};
		else if (inc)
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// ------------------------------------------------------------
	// Taps
	// ------------------------------------------------------------
	// Carry into bit i+1: one pulse each 2^(i+1) increments
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_tap
			assign carry[i] = inc & ~clear & (&count[i:0]);
		end
	endgenerate

endmodule // prescale_counter

// >>> src/timebase_timer.v
// Contract
// - System divider, 11-bit up-counter, reset clears
// - System divider holds in reset, watch, stop
// - Subactive mode counts subsystem clock ticks
// - Watch divider, 5-bit, crystal divided by eight
// - Watch divider cleared by software, stops in stop
// - Unit clocks come from divider taps
// - Timer 8-bit, reset clears, counts selected clock
// - Overflow wraps to zero, sets flag bit 2
// - Timebase bit selects watch divider taps
// - Codes 0-7 pick system taps 2048..2
// - Watch codes 32,16,8,2,1/2; 11x holds cleared
// - Reset code clears watch divider and timer
// - Mode register 4-bit write-only, reset zero
// - Reset code halts LCD, outputs grounded (here only lcd_halt is raised; no LCD outputs are driven)
//
// Chosen here: the AHB-Lite slave port.
`include "timebase_map.vh"

module timebase_timer (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Power mode and clock sources
	input  wire        watch_mode,
	input  wire        subactive_mode,
	input  wire        stop_mode,
	input  wire        sub_clk_tick,
	input  wire        crystal_input_pin,
	// Prescaler taps to other units
	output wire [10:0] system_taps,
	output wire [4:0]  watch_taps,
	// Timer events and LCD control
	output wire        irq,
	output reg         lcd_halt
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	// Registers
	reg  [3:0]  timer_mode_select;
	reg  [3:0]  irq_enable;
	reg  [3:0]  irq_status;
	reg  [7:0]  timebase_timer_count;
	reg         wr_pending;
	reg  [11:0] wr_addr;
	reg         crystal_prev;
	reg         watch_clear_cmd;
	reg         timer_tick;
	reg         sys_inc;

	// Bus decode and control
	wire        addr_phase;
	wire        wr_now;
	wire        crystal_rise;
	wire        stopped;
	wire        reset_code;
	wire        overflow;
	wire [3:0]  next_irq_status;

	// Divider states and carries
	wire [10:0] system_clock_divider;
	wire [4:0]  watch_clock_divider;
	wire [2:0]  crystal_div;
	wire [10:0] sys_carry;
	wire [4:0]  watch_carry;
	wire [2:0]  crystal_carry;

	// Mode register fields
	wire        timebase_select_bit;
	wire        clock_code_bit2;
	wire        clock_code_bit1;
	wire        clock_code_bit0;

	// Field aliases for the selectors
	assign timebase_select_bit = timer_mode_select[`BIT_TIMEBASE_SELECT];
	assign clock_code_bit2     = timer_mode_select[2];
	assign clock_code_bit1     = timer_mode_select[1];
	assign clock_code_bit0     = timer_mode_select[0];

	// ------------------------------------------------------------
	// Bus address phase
	// ------------------------------------------------------------
	// Zero wait state, always OKAY
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel & hready & htrans[1];
	assign wr_now     = wr_pending;

	// Latch a write for its data phase
	// Address kept so the data phase edge knows the target
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_pending <= 1'b0;
			wr_addr    <= 12'h000;
		end
		else
		begin
			wr_pending <= addr_phase & hwrite;
			wr_addr    <= haddr[11:0];
		end
	end

	// Read data registered at the address phase edge
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			hrdata <= 32'h00000000;
		else if (addr_phase & ~hwrite)
		begin
			case (haddr[11:0])
			`OFS_IRQ_STATUS:
				hrdata <= {28'h0000000, irq_status};
			`OFS_IRQ_ENABLE:
				hrdata <= {28'h0000000, irq_enable};
			`OFS_TIMER_COUNT:
				hrdata <= {24'h000000, timebase_timer_count};
			default:
				hrdata <= 32'h00000000; // Write-only and unmapped
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Mode register, write-only, cleared by reset
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			timer_mode_select <= `RST_TIMER_MODE_SELECT;
		else if (wr_now && wr_addr == `OFS_TIMER_MODE_SELECT)
			timer_mode_select <= hwdata[3:0];
	end

	// Interrupt enable
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_enable <= `RST_IRQ_ENABLE;
		else if (wr_now && wr_addr == `OFS_IRQ_ENABLE)
			irq_enable <= hwdata[3:0];
	end

	// Software clear command for the watch divider, one pulse
	// Crystal stage not cleared, first step may come early
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			watch_clear_cmd <= 1'b0;
		else
			watch_clear_cmd <= wr_now
				&& wr_addr == `OFS_WATCH_CLEAR
				&& hwdata[`BIT_WATCH_CLEAR_CMD];
	end

	// ------------------------------------------------------------
	// System divider
	// ------------------------------------------------------------
	// Source by power mode; held in watch and stop
	// Subactive steps follow the subsystem clock ticks
	always @*
	begin
		if (stop_mode | watch_mode)
			sys_inc = 1'b0;
		else if (subactive_mode)
			sys_inc = sub_clk_tick;
		else
			sys_inc = 1'b1;
	end

	prescale_counter #(
		.WIDTH (`SYS_DIV_WIDTH)
	) u_sys_div (
		.clk   (sys_clk),
		.rstn  (rstn),
		.clear (1'b0),
		.inc   (sys_inc),
		.count (system_clock_divider),
		.carry (sys_carry)
	);

	// Carry pulses feed the other units
	assign system_taps = sys_carry;

	// ------------------------------------------------------------
	// Watch divider
	// ------------------------------------------------------------
	// Crystal edge detect, input already synchronous
	// Idle level zero, so no false edge after reset
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			crystal_prev <= 1'b0;
		else
			crystal_prev <= crystal_input_pin;
	end

	assign crystal_rise = crystal_input_pin & ~crystal_prev;
	assign stopped      = stop_mode;
	assign reset_code   = timebase_select_bit
		& clock_code_bit2 & clock_code_bit1;

	// Crystal divided by eight
	prescale_counter #(
		.WIDTH (`CRYSTAL_DIV_WIDTH)
	) u_crystal_div (
		.clk   (sys_clk),
		.rstn  (rstn),
		.clear (1'b0),
		.inc   (crystal_rise & ~stopped),
		.count (crystal_div),
		.carry (crystal_carry)
	);

	// Watch divider held cleared by reset code or command
	prescale_counter #(
		.WIDTH (`WATCH_DIV_WIDTH)
	) u_watch_div (
		.clk   (sys_clk),
		.rstn  (rstn),
		.clear (reset_code | watch_clear_cmd),
		.inc   (crystal_carry[`TAP_CRYSTAL_EIGHTH] & ~stopped),
		.count (watch_clock_divider),
		.carry (watch_carry)
	);

	// Watch carries feed the other units
	assign watch_taps = watch_carry;

	// ------------------------------------------------------------
	// Timer clock selection
	// ------------------------------------------------------------
	// Tap chosen by the mode register
	// With the timebase bit set, codes 101 and 11x give no ticks
	always @*
	begin
		if (!timebase_select_bit)
		begin
			case (timer_mode_select[2:0])
			3'h0:    timer_tick = sys_carry[`TAP_SYS_2048];
			3'h1:    timer_tick = sys_carry[`TAP_SYS_1024];
			3'h2:    timer_tick = sys_carry[`TAP_SYS_512];
			3'h3:    timer_tick = sys_carry[`TAP_SYS_128];
			3'h4:    timer_tick = sys_carry[`TAP_SYS_32];
			3'h5:    timer_tick = sys_carry[`TAP_SYS_8];
			3'h6:    timer_tick = sys_carry[`TAP_SYS_4];
			default: timer_tick = sys_carry[`TAP_SYS_2];
			endcase
		end
		else
		begin
			case (timer_mode_select[2:0])
			3'h0:    timer_tick = watch_carry[`TAP_WATCH_32];
			3'h1:    timer_tick = watch_carry[`TAP_WATCH_16];
			3'h2:    timer_tick = watch_carry[`TAP_WATCH_8];
			3'h3:    timer_tick = watch_carry[`TAP_WATCH_2];
			3'h4:    timer_tick = crystal_carry[`TAP_CRYSTAL_HALF]
				& ~stopped;
			default: timer_tick = 1'b0; // Unused and reset codes
			endcase
		end
	end

	// ------------------------------------------------------------
	// Timer counter
	// ------------------------------------------------------------
	// Tick at all ones is an overflow
	assign overflow = timer_tick & ~reset_code
		& (timebase_timer_count == `TIMER_ALL_ONES);

	// Counts selected ticks, wraps, held clear by reset code
	// Reset code wins over a tick in the same cycle
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			timebase_timer_count <= `RST_TIMER_COUNT;
		else if (reset_code)
			timebase_timer_count <= `RST_TIMER_COUNT;
		else if (timer_tick)
			timebase_timer_count <= timebase_timer_count + 8'h01;
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Sticky status, set wins over clear
	// Only the overflow flag exists; other bits read zero
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1)
		begin : g_status
			if (b == `BIT_TIMER_OVERFLOW)
			begin : g_ovf
				assign next_irq_status[b] = overflow | (irq_status[b]
					& ~(wr_now && wr_addr == `OFS_IRQ_CLEAR
					&& hwdata[b]));
			end
			else
			begin : g_none
				assign next_irq_status[b] = 1'b0;
			end
		end
	endgenerate

	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			irq_status <= `RST_IRQ_STATUS;
		else
			irq_status <= next_irq_status;
	end

	// Level request while an enabled flag is set
	assign irq = |(irq_status & irq_enable);

	// ------------------------------------------------------------
	// LCD halt
	// ------------------------------------------------------------
	// High while the reset code is selected
	// Registered, trails the mode write by one cycle
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			lcd_halt <= 1'b0;
		else
			lcd_halt <= reset_code;
	end

endmodule // timebase_timer

// >>> tb/timebase_timer_monitor.sv
module timebase_timer_monitor (
	// Clock and reset
	input logic        sys_clk,
	input logic        rstn,
	// Bus
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata,
	// Modes and clocks
	input logic        watch_mode,
	input logic        subactive_mode,
	input logic        stop_mode,
	input logic        sub_clk_tick,
	input logic        crystal_input_pin,
	// Outputs
	input logic [10:0] system_taps,
	input logic [4:0]  watch_taps,
	input logic        irq,
	input logic        lcd_halt
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Address phase capture
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic wr_mode;
	logic wr_en;
	logic rd_mode;
	wire  take = hsel && hready && htrans[1];
	wire  act  = !watch_mode && !stop_mode && !subactive_mode;

	// Remember which register the data phase belongs to
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_mode <= 1'b0;
			wr_en   <= 1'b0;
			rd_mode <= 1'b0;
		end
		else
		begin
			wr_mode <= take && hwrite && haddr[11:0] == 12'h008;
			wr_en   <= take && hwrite && haddr[11:0] == 12'h004;
			rd_mode <= take && !hwrite && haddr[11:0] == 12'h008;
		end
	end

	// Checks
	chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus answer not okay");
	chk_sys_toggle: assert property (act [*3] |->
		system_taps[0] != $past(system_taps[0])) else $error("sys step");
	chk_sys_chain: assert property (system_taps[10] |-> &system_taps)
		else $error("sys tap chain");
	chk_watch_chain: assert property (watch_taps[4] |-> &watch_taps)
		else $error("watch tap chain");
	chk_sys_hold: assert property ((watch_mode || stop_mode) |->
		system_taps == 11'h000) else $error("sys divider runs");
	chk_watch_stop: assert property (stop_mode |->
		watch_taps == 5'h00) else $error("watch divider runs");
	chk_lcd_halt: assert property (wr_mode && hwdata[3:1] == 3'h7 |->
		##[1:2] lcd_halt) else $error("lcd not halted");
	chk_lcd_run: assert property (wr_mode && hwdata[3:1] != 3'h7 |->
		##2 !lcd_halt) else $error("lcd still halted");
	chk_irq_mask: assert property (wr_en && hwdata[3:0] == 4'h0 |->
		##1 !irq) else $error("irq not masked");
	chk_wo_read: assert property (rd_mode |-> hrdata == 32'h0)
		else $error("mode register readable");
	chk_reset_hold: assert property (lcd_halt |-> watch_taps == 5'h00)
		else $error("watch divider runs in reset code");
endmodule // timebase_timer_monitor

bind timebase_timer timebase_timer_monitor u_timebase_timer_monitor (
	.sys_clk           (sys_clk),
	.rstn              (rstn),
	.hsel              (hsel),
	.haddr             (haddr),
	.htrans            (htrans),
	.hwrite            (hwrite),
	.hsize             (hsize),
	.hwdata            (hwdata),
	.hready            (hready),
	.hreadyout         (hreadyout),
	.hresp             (hresp),
	.hrdata            (hrdata),
	.watch_mode        (watch_mode),
	.subactive_mode    (subactive_mode),
	.stop_mode         (stop_mode),
	.sub_clk_tick      (sub_clk_tick),
	.crystal_input_pin (crystal_input_pin),
	.system_taps       (system_taps),
	.watch_taps        (watch_taps),
	.irq               (irq),
	.lcd_halt          (lcd_halt)
);

// >>> tb/timebase_timer_tb.sv
module timebase_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------------
	logic        sys_clk, rstn, hsel, hwrite, watch_mode, subactive_mode;
	logic        stop_mode, sub_clk_tick, crystal_input_pin, xtal_on;
	logic [31:0] haddr, hwdata, q, c0;
	logic [1:0]  htrans, xc;
	logic [2:0]  hsize;
	logic [3:0]  en;
	wire         hready, hreadyout, hresp, irq, lcd_halt;
	wire  [31:0] hrdata;
	wire  [10:0] system_taps;
	wire  [4:0]  watch_taps;
	int          miscompares, checked, i, k;
	int          sys_p[8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
	int          tb_p[5]  = '{1024, 512, 256, 64, 16};

	timebase_timer u_timebase_timer (
		.sys_clk           (sys_clk),
		.rstn              (rstn),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (hsize),
		.hwdata            (hwdata),
		.hready            (hready),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.hrdata            (hrdata),
		.watch_mode        (watch_mode),
		.subactive_mode    (subactive_mode),
		.stop_mode         (stop_mode),
		.sub_clk_tick      (sub_clk_tick),
		.crystal_input_pin (crystal_input_pin),
		.system_taps       (system_taps),
		.watch_taps        (watch_taps),
		.irq               (irq),
		.lcd_halt          (lcd_halt)
	);
	assign hready = hreadyout;

	// Clock
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Crystal rises every 4 cycles, subsystem tick every 4 cycles
	always @(posedge sys_clk)
	begin
		xc <= xc + 2'h1;
		if (xtal_on && xc[0])
			crystal_input_pin <= ~crystal_input_pin;
		sub_clk_tick <= subactive_mode && xc == 2'h3;
	end

	task automatic check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One single-word transfer
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// Ticks seen over 256 cycles against the expected count
	task automatic rate(input logic [3:0] m, input int e);
		logic [7:0] d;
		int         di;
		if (m[3]) bus(1'b1, 12'h008, 32'hE, q);
		bus(1'b1, 12'h008, {28'h0, m}, q);
		bus(1'b0, 12'h010, 32'h0, c0);
		repeat (253) @(posedge sys_clk);
		bus(1'b0, 12'h010, 32'h0, q);
		d  = q[7:0] - c0[7:0];
		di = d;
		check("tick rate", {31'h0, di >= e - 1 && di <= e + 1}, 32'h1);
	endtask

	// Watchdog
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		wrap_up;
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h31487F69));
		{rstn, hsel, hwrite, watch_mode, subactive_mode, stop_mode} = 6'h0;
		{sub_clk_tick, crystal_input_pin, xtal_on, xc} = 5'h0;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		bus(1'b0, 12'h008, 32'h0, q); check("mode", q, 32'h0);
		bus(1'b0, 12'h010, 32'h0, q); check("count", q, 32'h0);
		bus(1'b0, 12'h000, 32'h0, q); check("status", q, 32'h0);
		bus(1'b0, 12'h040, 32'h0, q); check("unmapped", q, 32'h0);
		xtal_on <= 1'b1;
		for (i = 0; i < 8; i++) rate(i[3:0], 256 / sys_p[i]);
		for (i = 0; i < 3; i++)
		begin
			k = $urandom % 8;
			rate(k[3:0], 256 / sys_p[k]);
		end
		for (i = 0; i < 5; i++) rate(4'h8 + i[3:0], 256 / tb_p[i]);
		rate(4'hD, 0);
		bus(1'b1, 12'h008, 32'hE, q);
		@(posedge sys_clk);
		@(negedge sys_clk);
		check("lcd halt", lcd_halt, 1'b1);
		bus(1'b0, 12'h010, 32'h0, q); check("held", q, 32'h0);
		bus(1'b1, 12'h00C, 32'h4, q);
		bus(1'b1, 12'h004, 32'h4, q);
		rate(4'h7, 128);
		for (i = 0; i < 700 && irq !== 1'b1; i++) @(posedge sys_clk);
		check("irq", irq, 1'b1);
		bus(1'b0, 12'h000, 32'h0, q); check("flag", q[2], 1'b1);
		bus(1'b0, 12'h010, 32'h0, q); check("wrap", q < 32, 1'b1);
		en = $urandom;
		bus(1'b1, 12'h004, {28'h0, en}, q);
		@(negedge sys_clk); check("irq enable", irq, en[2]);
		bus(1'b0, 12'h004, 32'h0, q);
		check("enable", q, {28'h0, en});
		bus(1'b1, 12'h004, 32'h0, q);
		bus(1'b0, 12'h000, 32'h0, q); check("sticky", q[2], 1'b1);
		bus(1'b1, 12'h00C, 32'h4, q);
		bus(1'b0, 12'h000, 32'h0, q); check("cleared", q[2], 1'b0);
		watch_mode <= 1'b1;
		rate(4'hC, 16);
		rate(4'h7, 0);
		watch_mode <= 1'b0;
		subactive_mode <= 1'b1;
		rate(4'h7, 32);
		subactive_mode <= 1'b0;
		stop_mode <= 1'b1;
		rate(4'hC, 0);
		stop_mode <= 1'b0;
		bus(1'b1, 12'h014, 32'h1, q);
		rate(4'hC, 16);
		// Watch clear restarts the 16-step period from zero
		bus(1'b1, 12'h008, 32'hE, q);
		bus(1'b1, 12'h008, 32'h9, q);
		repeat (300) @(posedge sys_clk);
		bus(1'b1, 12'h014, 32'h1, q);
		repeat (400) @(posedge sys_clk);
		bus(1'b0, 12'h010, 32'h0, q);
		check("clear hold", q, 32'h0);
		repeat (150) @(posedge sys_clk);
		bus(1'b0, 12'h010, 32'h0, q);
		check("clear tick", q, 32'h1);
		wrap_up;
	end
endmodule // timebase_timer_tb
